// [common/ca_map.svh]
// Register map and timing constants of the counter array control block.
// Assumes inclusion by bare name from design files.
`ifndef CA_MAP_SVH
`define CA_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CA_CTRL_STATUS_ADDR 8'hd8
`define CA_MODE_CONFIG_ADDR 8'hd9

// ----------------------------------------------------------------------
// Control/status field positions
// ----------------------------------------------------------------------
`define CA_CS_OVF_BIT 7
`define CA_CS_RUN_BIT 6
`define CA_CS_RSVD_BIT 5
`define CA_CS_EVT_LSB 0
`define CA_CS_EVT_MSB 4

// ----------------------------------------------------------------------
// Mode config field positions
// ----------------------------------------------------------------------
`define CA_MC_IDLE_BIT 7
`define CA_MC_WDOG_BIT 6
`define CA_MC_SRC_LSB 1
`define CA_MC_SRC_MSB 2
`define CA_MC_OVFIE_BIT 0
`define CA_MC_WR_MASK 8'hc7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CA_CS_RESET 8'h00
`define CA_MC_RESET 8'h00
`define CA_CNT_RESET 16'h0000

// ----------------------------------------------------------------------
// Prescale divides in clocks
// ----------------------------------------------------------------------
`define CA_DIV_SLOW 4'hc
`define CA_DIV_SLOW_X2 4'h6
`define CA_DIV_FAST 4'h4
`define CA_DIV_FAST_X2 4'h2

`endif

// [common/ca_pkg.sv]
// Types of the counter array control block.
// Assumes the map header supplies all numeric constants.
package ca_pkg;
	typedef enum logic [1:0] {
		CA_SRC_DIV_SLOW = 2'b00,
		CA_SRC_DIV_FAST = 2'b01,
		CA_SRC_TIMER0 = 2'b10,
		CA_SRC_EXT_PIN = 2'b11
	} ca_src_t;

	typedef enum logic [1:0] {
		CA_ST_STOP = 2'b00,
		CA_ST_RUN = 2'b01,
		CA_ST_IDLE_HOLD = 2'b10
	} ca_state_t;
endpackage

// [src/ca_prescaler.sv]
// Divider giving one pulse every div clocks.
// Assumes div is at least 1 and steady while enabled.
`timescale 1ns/10ps
module ca_prescaler (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Control
	input wire logic enable,
	input wire logic [3:0] div,
	// Output
	output logic tick
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		tick = 1'b0;
		if (!enable) begin
			cnt_d = 4'h0;
		end else if (cnt_q >= div - 4'h1) begin
			cnt_d = 4'h0;
			tick = 1'b1;
		end else begin
			cnt_d = cnt_q + 4'h1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

// [src/ca_edge_sync.sv]
// Two-stage synchroniser with rising edge detect for a pin input.
// Assumes the pin is asynchronous to clock.
`timescale 1ns/10ps
module ca_edge_sync (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Pin
	input wire logic pin,
	// Outputs
	output logic level,
	output logic rise
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise = sync_q & ~last_q;
endmodule

// [src/ca_control.sv]
// Control and status logic of the counter array: time base source,
// run and idle halt, watchdog enable, overflow and module event flags.
// Assumes a simple synchronous register port from the host core and
// module event pulses from the capture/compare modules on this clock.
`timescale 1ns/10ps
`include "ca_map.svh"
module ca_control (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_hit,
	// Core state
	input wire logic double_speed_mode,
	input wire logic cpu_idle,
	input wire logic timer0_overflow,
	// Pin
	input wire logic external_count_input,
	// Module side
	input wire logic [4:0] module_event,
	input wire logic [4:0] module_event_irq_enable,
	output logic [15:0] count_value,
	output logic count_tick,
	output logic watchdog_enable,
	output logic [4:0] module_wdog_allowed,
	// Interrupt and status
	output logic irq_request,
	output logic counter_running
);
	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [7:0] cs_q;
	logic [7:0] cs_d;
	logic [7:0] mc_q;
	logic [7:0] mc_d;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	ca_pkg::ca_state_t st_q;
	ca_pkg::ca_state_t st_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic hit_q;
	logic hit_d;
	logic irq_q;
	logic irq_d;
	logic tick_q;
	logic tick_d;
	logic wdog_q;
	logic wdog_d;
	logic run_out_q;
	logic run_out_d;

	logic ext_rise;
	logic idle_halt;
	logic div_tick;
	logic [3:0] div_sel;
	logic pre_en;
	logic step;
	logic ovf_event;
	logic [4:0] evt_hw;
	ca_pkg::ca_src_t src;

	assign src = ca_pkg::ca_src_t'(mc_q[`CA_MC_SRC_MSB:`CA_MC_SRC_LSB]);

	// Core idle only halts the count when the halt option is chosen
	assign idle_halt = cpu_idle && mc_q[`CA_MC_IDLE_BIT];

	// ------------------------------------------------------------------
	// Count pulse sources
	// ------------------------------------------------------------------
	ca_edge_sync u_ext_sync (
		.clock(clock),
		.arst_n(arst_n),
		.pin(external_count_input),
		.level(),
		.rise(ext_rise)
	);

	always_comb begin
		case (src)
			ca_pkg::CA_SRC_DIV_SLOW: begin
				div_sel = double_speed_mode ? `CA_DIV_SLOW_X2
					: `CA_DIV_SLOW;
			end
			ca_pkg::CA_SRC_DIV_FAST: begin
				div_sel = double_speed_mode ? `CA_DIV_FAST_X2
					: `CA_DIV_FAST;
			end
			default: begin
				div_sel = `CA_DIV_FAST;
			end
		endcase
	end

	// Prescaler is held clear while stopped so restart phase is known
	assign pre_en = (st_q == ca_pkg::CA_ST_RUN) &&
		(src == ca_pkg::CA_SRC_DIV_SLOW || src == ca_pkg::CA_SRC_DIV_FAST);

	ca_prescaler u_prescaler (
		.clock(clock),
		.arst_n(arst_n),
		.enable(pre_en),
		.div(div_sel),
		.tick(div_tick)
	);

	// Synchroniser delays the pin by two clocks; edges faster than
	// the pin rate limit may be merged
	always_comb begin
		case (src)
			ca_pkg::CA_SRC_DIV_SLOW: step = div_tick;
			ca_pkg::CA_SRC_DIV_FAST: step = div_tick;
			ca_pkg::CA_SRC_TIMER0: step = timer0_overflow;
			ca_pkg::CA_SRC_EXT_PIN: step = ext_rise;
			default: step = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// Run state
	// ------------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		case (st_q)
			ca_pkg::CA_ST_STOP: begin
				if (cs_q[`CA_CS_RUN_BIT] && idle_halt) begin
					// Starting while idle must not count a single step
					st_d = ca_pkg::CA_ST_IDLE_HOLD;
				end else if (cs_q[`CA_CS_RUN_BIT]) begin
					st_d = ca_pkg::CA_ST_RUN;
				end
			end
			ca_pkg::CA_ST_RUN: begin
				if (!cs_q[`CA_CS_RUN_BIT]) begin
					st_d = ca_pkg::CA_ST_STOP;
				end else if (idle_halt) begin
					st_d = ca_pkg::CA_ST_IDLE_HOLD;
				end
			end
			ca_pkg::CA_ST_IDLE_HOLD: begin
				if (!cs_q[`CA_CS_RUN_BIT]) begin
					st_d = ca_pkg::CA_ST_STOP;
				end else if (!idle_halt) begin
					st_d = ca_pkg::CA_ST_RUN;
				end
			end
			default: begin
				st_d = ca_pkg::CA_ST_STOP;
			end
		endcase
		run_out_d = (st_d == ca_pkg::CA_ST_RUN);
	end

	// Status output follows the state without a further lag
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= ca_pkg::CA_ST_STOP;
			run_out_q <= 1'b0;
		end else begin
			st_q <= st_d;
			run_out_q <= run_out_d;
		end
	end

	// ------------------------------------------------------------------
	// Time base
	// ------------------------------------------------------------------
	always_comb begin
		cnt_d = cnt_q;
		ovf_event = 1'b0;
		tick_d = 1'b0;
		// Idle is honoured at once, before the state has caught up
		if (st_q == ca_pkg::CA_ST_RUN && !idle_halt && step) begin
			cnt_d = cnt_q + 16'h0001;
			tick_d = 1'b1;
			ovf_event = (cnt_q == 16'hffff);
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= `CA_CNT_RESET;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	// ------------------------------------------------------------------
	// Register writes and flags
	// ------------------------------------------------------------------
	// Module functions themselves live in the module blocks; here only
	// their match/capture events arrive
	assign evt_hw = module_event;

	always_comb begin
		cs_d = cs_q;
		mc_d = mc_q;
		if (reg_wr && reg_addr == `CA_CTRL_STATUS_ADDR) begin
			// Flags take the written value, so writing 0 clears them
			cs_d = reg_wdata;
			cs_d[`CA_CS_RSVD_BIT] = 1'b0;
		end
		if (reg_wr && reg_addr == `CA_MODE_CONFIG_ADDR) begin
			mc_d = reg_wdata & `CA_MC_WR_MASK;
		end
		// Hardware sets come last so they win over a clear
		if (ovf_event) begin
			cs_d[`CA_CS_OVF_BIT] = 1'b1;
		end
		cs_d[`CA_CS_EVT_MSB:`CA_CS_EVT_LSB] =
			cs_d[`CA_CS_EVT_MSB:`CA_CS_EVT_LSB] | evt_hw;
		wdog_d = mc_d[`CA_MC_WDOG_BIT];
	end

	// Watchdog copy is taken from the next value so it tracks the field
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cs_q <= `CA_CS_RESET;
			mc_q <= `CA_MC_RESET;
			wdog_q <= 1'b0;
		end else begin
			cs_q <= cs_d;
			mc_q <= mc_d;
			wdog_q <= wdog_d;
		end
	end

	// ------------------------------------------------------------------
	// Read port and outputs
	// ------------------------------------------------------------------
	always_comb begin
		rdata_d = 8'h00;
		hit_d = 1'b0;
		if (reg_rd && reg_addr == `CA_CTRL_STATUS_ADDR) begin
			rdata_d = cs_q;
			hit_d = 1'b1;
		end else if (reg_rd && reg_addr == `CA_MODE_CONFIG_ADDR) begin
			rdata_d = mc_q;
			hit_d = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= 8'h00;
			hit_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			hit_q <= hit_d;
		end
	end

	always_comb begin
		irq_d = (cs_q[`CA_CS_OVF_BIT] & mc_q[`CA_MC_OVFIE_BIT])
			| (|(cs_q[`CA_CS_EVT_MSB:`CA_CS_EVT_LSB]
			& module_event_irq_enable));
	end

	// Level request, one clock behind the flags that raise it
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_hit = hit_q;
	assign irq_request = irq_q;
	assign count_value = cnt_q;
	assign count_tick = tick_q;
	assign watchdog_enable = wdog_q;
	assign module_wdog_allowed = {wdog_q, 4'h0};
	assign counter_running = run_out_q;
endmodule

// [verif/ca_control_props.sv]
// Port checker of the counter array control block.
// Assumes it is bound to ca_control and sees only its ports.
`timescale 1ns/10ps
module ca_control_props (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_hit,
	// Module side and status
	input wire logic [4:0] module_event,
	input wire logic [4:0] module_event_irq_enable,
	input wire logic [15:0] count_value,
	input wire logic watchdog_enable,
	input wire logic [4:0] module_wdog_allowed,
	input wire logic irq_request,
	input wire logic counter_running
);
	// --------------------------------------------------------------
	// Properties
	// --------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence s_rd_map;
		reg_rd && (reg_addr == 8'hd8 || reg_addr == 8'hd9);
	endsequence
	// Three cycles are margin only; the count already holds after one cycle with the run status low
	sequence s_stopped;
		!counter_running [*3];
	endsequence
	property p_wdog_only4;
		module_wdog_allowed == {watchdog_enable, 4'h0};
	endproperty
	a_wdog_only4: assert property (p_wdog_only4) else $error("wdog mask");
	property p_wdog_wr;
		reg_wr && reg_addr == 8'hd9
			|=> watchdog_enable == $past(reg_wdata[6]);
	endproperty
	a_wdog_wr: assert property (p_wdog_wr) else $error("wdog enable");
	property p_rd_unmap;
		reg_rd && !(reg_addr inside {8'hd8, 8'hd9})
			|=> reg_rdata == 8'h00 && !reg_hit;
	endproperty
	a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read");
	property p_rd_hit;
		s_rd_map |=> reg_hit;
	endproperty
	a_rd_hit: assert property (p_rd_hit) else $error("read hit");
	property p_idle_bus;
		!reg_rd |=> reg_rdata == 8'h00 && !reg_hit;
	endproperty
	a_idle_bus: assert property (p_idle_bus) else $error("idle bus");
	property p_stop_hold;
		s_stopped |=> $stable(count_value);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("count moved");
	property p_step;
		$changed(count_value) |-> count_value == $past(count_value) + 16'h1;
	endproperty
	a_step: assert property (p_step) else $error("count step");
	property p_evt_irq;
		|(module_event & module_event_irq_enable) |-> ##[1:3] irq_request;
	endproperty
	a_evt_irq: assert property (p_evt_irq) else $error("event irq");
endmodule
bind ca_control ca_control_props u_props (
	.clock(clock),
	.arst_n(arst_n),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.reg_hit(reg_hit),
	.module_event(module_event),
	.module_event_irq_enable(module_event_irq_enable),
	.count_value(count_value),
	.watchdog_enable(watchdog_enable),
	.module_wdog_allowed(module_wdog_allowed),
	.irq_request(irq_request),
	.counter_running(counter_running)
);

// [verif/tb_top.sv]
// Self-checking bench of the counter array control block.
// Assumes the design and its checker are compiled before it.
`timescale 1ns/10ps
module tb_top;
	// --------------------------------------------------------------
	// Stimulus and checks
	// --------------------------------------------------------------
	logic clock = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv, x;
	logic ds = 1'b0, idle = 1'b0, t0 = 1'b0, pin = 1'b0;
	logic [4:0] ev = 5'h00, en = 5'h00, wd_ok, f;
	logic hit, tick, wd, irq, run;
	logic [15:0] cnt, c0;
	integer seed = 32'h391960d5;
	integer n_errors = 0, n_tests = 0, cyc = 0, i, n, n_tk = 0, k0;
	always #50 clock = ~clock;
	ca_control dut (.clock(clock), .arst_n(arst_n), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_hit(hit), .double_speed_mode(ds),
		.cpu_idle(idle), .timer0_overflow(t0),
		.external_count_input(pin), .module_event(ev),
		.module_event_irq_enable(en), .count_value(cnt),
		.count_tick(tick), .watchdog_enable(wd),
		.module_wdog_allowed(wd_ok), .irq_request(irq),
		.counter_running(run));
	function automatic logic [15:0] div_of(input logic fast, dbl);
		return fast ? (dbl ? 16'h2 : 16'h4) : (dbl ? 16'h6 : 16'hc);
	endfunction
	task automatic chk(input string nm, input logic [15:0] s, e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_of_test();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(negedge clock);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clock);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge clock);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clock);
		reg_rd = 1'b0;
		rv = reg_rdata;
	endtask
	task automatic pulse(input integer k);
		repeat (k) begin
			@(negedge clock);
			t0 = 1'b1;
			@(negedge clock);
			t0 = 1'b0;
		end
		repeat (4) @(negedge clock);
	endtask
	always @(posedge clock) begin
		cyc++;
		if (tick === 1'b1)
			n_tk++;
		if (cyc == 80000) begin
			n_errors++;
			end_of_test();
		end
	end
	initial begin
		repeat (16) @(negedge clock);
		arst_n = 1'b1;
		rd(8'hd8);
		chk("cs reset", rv, 8'h00);
		for (i = 0; i < 4; i++) begin
			x = (i == 0) ? 8'hff : 8'($random(seed));
			wr(8'hd9, x);
			rd(8'hd9);
			chk("mode", rv, x & 8'hc7);
			chk("wdog", {wd_ok, wd}, {x[6], 4'h0, x[6]});
			x = 8'($random(seed));
			if (x[7:1] == 7'h6c)
				x = 8'h00;
			rd(x);
			chk("unmapped", {hit, rv}, 9'h0);
		end
		wr(8'hd9, 8'h00);
		for (i = 0; i < 4; i++) begin
			f = (i == 0) ? 5'h1f : 5'($random(seed));
			en = (i == 0) ? 5'h00 : 5'($random(seed));
			wr(8'hd8, 8'h00);
			@(negedge clock);
			ev = f;
			@(negedge clock);
			ev = 5'h00;
			repeat (3) @(negedge clock);
			chk("irq", irq, |(f & en));
			rd(8'hd8);
			chk("flags", rv, {3'h0, f});
		end
		// Clear and set meet in one cycle
		@(negedge clock);
		reg_wr = 1'b1;
		reg_addr = 8'hd8;
		reg_wdata = 8'h00;
		ev = 5'h04;
		@(negedge clock);
		reg_wr = 1'b0;
		ev = 5'h00;
		rd(8'hd8);
		chk("set wins", rv, 8'h04);
		wr(8'hd9, 8'h04);
		wr(8'hd8, 8'h40);
		n = 1 + ($random(seed) & 7);
		c0 = cnt;
		k0 = n_tk;
		pulse(n);
		chk("t0 count", cnt, 16'(c0 + n));
		chk("ticks", 16'(n_tk - k0), 16'(n));
		chk("running", run, 1'b1);
		wr(8'hd8, 8'h00);
		c0 = cnt;
		pulse(3);
		chk("stopped", cnt, c0);
		chk("halted", run, 1'b0);
		wr(8'hd9, 8'h84);
		wr(8'hd8, 8'h40);
		idle = 1'b1;
		c0 = cnt;
		pulse(3);
		chk("idle halt", cnt, c0);
		chk("idle state", run, 1'b0);
		wr(8'hd9, 8'h04);
		c0 = cnt;
		pulse(3);
		chk("idle run", cnt, 16'(c0 + 3));
		idle = 1'b0;
		for (i = 0; i < 4; i++) begin
			wr(8'hd8, 8'h00);
			ds = i[1];
			wr(8'hd9, {5'h0, 1'b0, i[0], 1'b0});
			wr(8'hd8, 8'h40);
			repeat (20) @(negedge clock);
			c0 = cnt;
			repeat (8 * div_of(i[0], i[1])) @(negedge clock);
			chk("prescale", cnt - c0, 16'h8);
		end
		wr(8'hd9, 8'h06);
		n = 1 + ($random(seed) & 7);
		repeat (6) @(negedge clock);
		c0 = cnt;
		// Eight clocks a pulse, the fastest rate the pin may carry
		repeat (n) begin
			pin = 1'b1;
			repeat (4) @(negedge clock);
			pin = 1'b0;
			repeat (4) @(negedge clock);
		end
		chk("pin count", cnt, 16'(c0 + n));
		wr(8'hd9, 8'h04);
		t0 = 1'b1;
		while (cnt !== 16'hffff)
			@(negedge clock);
		repeat (4) @(negedge clock);
		t0 = 1'b0;
		rd(8'hd8);
		chk("overflow", rv, 8'hc0);
		wr(8'hd9, 8'h05);
		repeat (3) @(negedge clock);
		chk("ovf irq on", irq, 1'b1);
		wr(8'hd9, 8'h04);
		repeat (3) @(negedge clock);
		chk("ovf irq off", irq, 1'b0);
		wr(8'hd8, 8'h40);
		rd(8'hd8);
		chk("ovf clear", rv, 8'h40);
		end_of_test();
	end
endmodule
